//--- mpc_consts.vh
// Purpose: shared constants for the pin control logic
// Assumes: included by bare name from the design files that use its macros
// Notes: mode codes follow {mode_select_b, mode_select_a}
`ifndef MPC_CONSTS_VH
`define MPC_CONSTS_VH

// ----------------------------------------
// clocking
// ----------------------------------------
`define MPC_OSC_PER_BUS 4
`define MPC_INT_RESET_WINDOW 4

// ----------------------------------------
// operating modes
// ----------------------------------------
`define MPC_MODE_BOOT 2'h0
`define MPC_MODE_SINGLE 2'h1
`define MPC_MODE_TEST 2'h2
`define MPC_MODE_EXPANDED 2'h3

// ----------------------------------------
// clock-out divide select codes
// ----------------------------------------
`define MPC_XDIV_1 2'h0
`define MPC_XDIV_2 2'h1
`define MPC_XDIV_4 2'h2
`define MPC_XDIV_8 2'h3

// ----------------------------------------
// reset values
// ----------------------------------------
`define MPC_XDIV_RESET 2'h0
`define MPC_PHASE_RESET 2'h0

`endif

//--- mpc_sync2.v
// Purpose: two flip-flop synchroniser for one pin level
// Assumes: input is asynchronous to clk_sys
// Notes: the first stage feeds only the second
`timescale 1ns/100ps
`default_nettype none

module mpc_sync2 #(
  parameter RESET_VAL = 1'b1
) (
  // clock and reset
  input wire clk_sys,
  input wire reset,
  // data
  input wire async_in,
  output reg sync_out
);

  reg meta_q;

  always @(posedge clk_sys) begin
    if (reset) begin
      meta_q <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule
`default_nettype wire

//--- mpc_clkdiv.v
// Purpose: divider for the buffered oscillator clock output
// Assumes: enable comes from a register on clk_sys
// Notes: divide by one toggles tick on every running clk_sys edge, half the oscillator rate
`timescale 1ns/100ps
`default_nettype none
`include "mpc_consts.vh"

module mpc_clkdiv (
  // clock and reset
  input wire clk_sys,
  input wire reset,
  // control
  input wire run,
  input wire [1:0] div_sel,
  // output
  output reg tick
);

  reg [3:0] cnt_q;

  // ----------------------------------------
  // divider
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (reset) begin
      cnt_q <= 4'h0;
      tick <= 1'b0;
    end else if (run) begin
      cnt_q <= cnt_q + 4'h1;
      case (div_sel)
        `MPC_XDIV_1: tick <= ~tick;
        `MPC_XDIV_2: tick <= cnt_q[1];
        `MPC_XDIV_4: tick <= cnt_q[2];
        `MPC_XDIV_8: tick <= cnt_q[3];
        default: tick <= 1'b0;
      endcase
    end
  end

endmodule
`default_nettype wire

//--- mpc_pin_ctrl.v
// Purpose: pin-level control: reset pin, bus clock, clock out, interrupts, modes, strobe, r/w, ports
// Assumes: clk_sys is the oscillator input; one clk_sys edge is one oscillator period
// Notes: open-drain pins use active-low output enables; data lines are always 0
`timescale 1ns/100ps
`default_nettype none
`include "mpc_consts.vh"

// Contract
// RULE_01 - reset pin input, open-drain on failures
// RULE_02 - pin high within four cycles means internal
// RULE_03 - bus clock is oscillator divided by four
// RULE_04 - low half internal, high half access
// RULE_05 - stop mode halts all clocks
// RULE_06 - bus clock output switchable in single-chip
// RULE_07 - clock out enabled, divide from two bits
// RULE_08 - clock out divide one after reset
// RULE_09 - maskable irq edge or level, level reset
// RULE_10 - reset sets nonmaskable mask bit
// RULE_11 - sources open-drain, hold low until acknowledged
// RULE_12 - held low line retriggers when unmasked
// RULE_13 - mode pins sampled during reset
// RULE_14 - mode pin becomes opcode fetch strobe
// RULE_15 - strobe goes high between instructions
// RULE_16 - strobe drive control bit gates strobe
// RULE_17 - r/w high read, low write expanded
// RULE_18 - r/w held low single-chip
// RULE_19 - bus ports general only single/boot
// RULE_20 - ten pins are input only
// RULE_21 - ports input high-impedance at reset
// RULE_22 - reset source kept in status flag
module mpc_pin_ctrl (
  // clock and reset
  input wire clk_sys,
  input wire reset,
  // reset pin
  input wire reset_pin_n_in,
  output reg reset_pin_out,
  output reg reset_pin_oe_n,
  input wire clock_monitor_fail,
  input wire watchdog_timer_fail,
  output reg reset_internal_flag,
  output reg core_reset,
  // bus clock and stop
  input wire stop_mode,
  input wire bus_clock_off,
  output reg bus_clock_out,
  output reg access_phase,
  // buffered oscillator clock
  input wire clock_out_enable_bit,
  input wire clock_out_divide_bit1,
  input wire clock_out_divide_bit2,
  output reg clock_out_pin,
  // interrupts
  input wire irq_pin_n,
  input wire irq_edge_select,
  input wire irq_mask_bit,
  input wire irq_ack,
  output reg irq_request,
  input wire nonmaskable_interrupt_pin,
  input wire nmi_mask_clear,
  output reg nmi_mask_bit,
  output reg nmi_request,
  // mode pins and strobe
  input wire mode_select_a,
  input wire mode_select_b,
  input wire strobe_drive_control_bit,
  input wire opcode_fetch,
  output reg [1:0] op_mode,
  output reg instruction_start_strobe_out,
  output reg instruction_start_strobe_oe_n,
  // read/write direction
  input wire bus_cycle_active,
  input wire bus_cycle_write,
  output reg read_write_pin,
  // ports
  input wire [7:0] port_b_ddr,
  input wire [7:0] port_c_ddr,
  input wire [7:0] port_f_ddr,
  output reg [7:0] port_b_oe_n,
  output reg [7:0] port_c_oe_n,
  output reg [7:0] port_f_oe_n,
  output reg ports_bus_function,
  input wire [7:0] port_e_pin,
  input wire input_only_pin_g7,
  input wire input_only_pin_g6,
  output reg [9:0] input_only_level
);

  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  wire rst_pin_s;
  wire irq_s;
  wire nmi_s;
  wire mode_a_s;
  wire mode_b_s;
  wire [9:0] inonly_s;

  mpc_sync2 #(.RESET_VAL(1'b1)) u_sync_rst (
    .clk_sys(clk_sys), .reset(reset), .async_in(reset_pin_n_in), .sync_out(rst_pin_s));
  mpc_sync2 #(.RESET_VAL(1'b1)) u_sync_irq (
    .clk_sys(clk_sys), .reset(reset), .async_in(irq_pin_n), .sync_out(irq_s));
  mpc_sync2 #(.RESET_VAL(1'b1)) u_sync_nmi (
    .clk_sys(clk_sys), .reset(reset), .async_in(nonmaskable_interrupt_pin), .sync_out(nmi_s));
  // mode pins keep sampling through reset, so the latch sees settled levels as reset lets go
  mpc_sync2 #(.RESET_VAL(1'b0)) u_sync_ma (
    .clk_sys(clk_sys), .reset(1'b0), .async_in(mode_select_a), .sync_out(mode_a_s));
  mpc_sync2 #(.RESET_VAL(1'b0)) u_sync_mb (
    .clk_sys(clk_sys), .reset(1'b0), .async_in(mode_select_b), .sync_out(mode_b_s));

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pe
      mpc_sync2 #(.RESET_VAL(1'b0)) u_sync_pe (
        .clk_sys(clk_sys), .reset(reset), .async_in(port_e_pin[gi]), .sync_out(inonly_s[gi]));
    end
  endgenerate
  mpc_sync2 #(.RESET_VAL(1'b0)) u_sync_g6 (
    .clk_sys(clk_sys), .reset(reset), .async_in(input_only_pin_g6), .sync_out(inonly_s[8]));
  mpc_sync2 #(.RESET_VAL(1'b0)) u_sync_g7 (
    .clk_sys(clk_sys), .reset(reset), .async_in(input_only_pin_g7), .sync_out(inonly_s[9]));

  // ----------------------------------------
  // reset pin and reset source
  // ----------------------------------------
  localparam RS_IDLE = 2'h0;
  localparam RS_DRIVE = 2'h1;
  localparam RS_SENSE = 2'h2;
  localparam RS_HOLD = 2'h3;
  localparam [5:0] DRIVE_CYCLES = 6'h20;
  localparam [4:0] SENSE_CYCLES = 5'h10;

  // the pin is pulled low a fixed time so that slow external circuits see it
  reg [1:0] rs_state_q;
  reg [5:0] rs_cnt_q;
  wire fail_any;
  assign fail_any = clock_monitor_fail | watchdog_timer_fail;

  always @(posedge clk_sys) begin
    if (reset) begin
      rs_state_q <= RS_IDLE;
      rs_cnt_q <= 6'h00;
      reset_pin_out <= 1'b0;
      reset_pin_oe_n <= 1'b1;
      reset_internal_flag <= 1'b0;
      core_reset <= 1'b1;
    end else begin
      reset_pin_out <= 1'b0;
      case (rs_state_q)
        RS_IDLE: begin
          // RULE_01 open-drain pull
          if (fail_any) begin
            rs_state_q <= RS_DRIVE;
            rs_cnt_q <= 6'h00;
            reset_pin_oe_n <= 1'b0;
            core_reset <= 1'b1;
          end else if (!rst_pin_s) begin
            rs_state_q <= RS_HOLD;
            core_reset <= 1'b1;
          end else begin
            core_reset <= 1'b0;
          end
        end
        RS_DRIVE: begin
          rs_cnt_q <= rs_cnt_q + 6'h01;
          if (rs_cnt_q == DRIVE_CYCLES - 6'h01) begin
            rs_state_q <= RS_SENSE;
            rs_cnt_q <= 6'h00;
            reset_pin_oe_n <= 1'b1;
          end
        end
        RS_SENSE: begin
          // RULE_02 four bus cycle window
          // two clocks of the window go to the pin synchroniser
          rs_cnt_q <= rs_cnt_q + 6'h01;
          if (rst_pin_s) begin
            // RULE_22 latch reset source
            reset_internal_flag <= 1'b1;
            rs_state_q <= RS_IDLE;
          end else if (rs_cnt_q[4:0] == SENSE_CYCLES - 5'h01) begin
            reset_internal_flag <= 1'b0;
            rs_state_q <= RS_HOLD;
          end
        end
        RS_HOLD: begin
          // RULE_01 external reset input
          if (rst_pin_s) begin
            reset_internal_flag <= 1'b0;
            rs_state_q <= RS_IDLE;
          end
        end
        default: rs_state_q <= RS_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // bus clock
  // ----------------------------------------
  // phase keeps its count through stop, so the bus clock resumes where it left off
  reg [1:0] phase_q;
  always @(posedge clk_sys) begin
    if (reset) begin
      phase_q <= `MPC_PHASE_RESET;
      bus_clock_out <= 1'b0;
      access_phase <= 1'b0;
    end else if (!stop_mode) begin
      // RULE_03 divide by four
      phase_q <= phase_q + 2'h1;
      // RULE_04 high half is access
      access_phase <= phase_q[1];
      // RULE_06 off only in single-chip and boot modes
      bus_clock_out <= phase_q[1] & ~(bus_clock_off &
        (op_mode == `MPC_MODE_SINGLE || op_mode == `MPC_MODE_BOOT));
    end else begin
      // RULE_05 stop halts clocks
      bus_clock_out <= 1'b0;
    end
  end

  // ----------------------------------------
  // buffered oscillator clock out
  // ----------------------------------------
  wire clock_out_enable_bit_tick;
  reg [1:0] xdiv_q;
  always @(posedge clk_sys) begin
    if (reset) begin
      // RULE_08 divide one after reset
      xdiv_q <= `MPC_XDIV_RESET;
      clock_out_pin <= 1'b0;
    end else begin
      xdiv_q <= {clock_out_divide_bit2, clock_out_divide_bit1};
      // RULE_07 gated by enable bit
      clock_out_pin <= clock_out_enable_bit & ~stop_mode & clock_out_enable_bit_tick;
    end
  end

  mpc_clkdiv u_clkdiv (
    .clk_sys(clk_sys),
    .reset(reset),
    .run(~stop_mode),
    .div_sel(xdiv_q),
    .tick(clock_out_enable_bit_tick)
  );

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  // the edge latch survives masking; only an acknowledge clears it
  reg irq_prev_q;
  reg irq_edge_q;
  reg irq_edge_mode_q;
  always @(posedge clk_sys) begin
    if (reset) begin
      irq_prev_q <= 1'b1;
      irq_edge_q <= 1'b0;
      // RULE_09 level after reset
      irq_edge_mode_q <= 1'b0;
      // RULE_10 mask set in reset
      nmi_mask_bit <= 1'b1;
      irq_request <= 1'b0;
      nmi_request <= 1'b0;
    end else begin
      irq_prev_q <= irq_s;
      irq_edge_mode_q <= irq_edge_select;
      // RULE_09 edge latch, set beats ack
      if (irq_prev_q && !irq_s)
        irq_edge_q <= 1'b1;
      else if (irq_ack)
        irq_edge_q <= 1'b0;
      if (nmi_mask_clear)
        nmi_mask_bit <= 1'b0;
      // RULE_12 level retriggers when unmasked
      irq_request <= ~irq_mask_bit & (irq_edge_mode_q ? irq_edge_q : ~irq_s);
      // RULE_11 shared line held low
      nmi_request <= ~nmi_mask_bit & ~nmi_s;
    end
  end

  // ----------------------------------------
  // mode latch and strobe
  // ----------------------------------------
  // RULE_13 sample during reset
  always @(posedge clk_sys) begin
    if (reset) begin
      op_mode <= `MPC_MODE_SINGLE;
    end else if (core_reset) begin
      op_mode <= {mode_b_s, mode_a_s};
    end
  end

  reg fetch_prev_q;
  wire strobe_gap;
  // a fetch still high at a new bus cycle start is the next instruction
  assign strobe_gap = fetch_prev_q & (phase_q == 2'h0);
  always @(posedge clk_sys) begin
    if (reset) begin
      fetch_prev_q <= 1'b0;
      instruction_start_strobe_out <= 1'b0;
      instruction_start_strobe_oe_n <= 1'b1;
    end else begin
      instruction_start_strobe_out <= 1'b0;
      fetch_prev_q <= opcode_fetch;
      // RULE_14 low on opcode fetch
      // RULE_15 released one cycle between fetches
      // RULE_16 drive control bit
      instruction_start_strobe_oe_n <= ~(~core_reset & strobe_drive_control_bit &
        opcode_fetch & ~strobe_gap);
    end
  end

  // ----------------------------------------
  // read/write and ports
  // ----------------------------------------
  wire bus_mode;
  assign bus_mode = (op_mode == `MPC_MODE_EXPANDED) || (op_mode == `MPC_MODE_TEST);
  always @(posedge clk_sys) begin
    if (reset) begin
      read_write_pin <= 1'b0;
      port_b_oe_n <= 8'hff;
      port_c_oe_n <= 8'hff;
      port_f_oe_n <= 8'hff;
      ports_bus_function <= 1'b0;
      input_only_level <= 10'h000;
    end else begin
      // reads drive high; writes and idle cycles leave the pin low
      // RULE_17 direction in bus modes
      // RULE_18 low in single-chip
      read_write_pin <= bus_mode & bus_cycle_active & ~bus_cycle_write;
      // RULE_19 general i/o single/boot only
      // RULE_21 inputs high-impedance at reset
      // ports stay inputs through core reset so no pin fights the bus at start-up
      ports_bus_function <= bus_mode & ~core_reset;
      port_b_oe_n <= (bus_mode | core_reset) ? 8'hff : ~port_b_ddr;
      port_c_oe_n <= (bus_mode | core_reset) ? 8'hff : ~port_c_ddr;
      port_f_oe_n <= (bus_mode | core_reset) ? 8'hff : ~port_f_ddr;
      // RULE_20 input-only pins
      input_only_level <= inonly_s;
    end
  end

endmodule
`default_nettype wire

//--- mpc_pin_ctrl_checker.sv
// Purpose: port checks for the pin control block
// Assumes: bound into every mpc_pin_ctrl
// Notes: settle times allow for registered outputs and 2-ff synced pins
`timescale 1ns/100ps
`default_nettype none
module mpc_pin_ctrl_checker (
  // clock and reset
  input wire clk_sys,
  input wire reset,
  // clocks
  input wire stop_mode,
  input wire bus_clock_off,
  input wire bus_clock_out,
  input wire access_phase,
  input wire clock_out_enable_bit,
  input wire clock_out_divide_bit1,
  input wire clock_out_divide_bit2,
  input wire clock_out_pin,
  // reset pin and interrupts
  input wire clock_monitor_fail,
  input wire watchdog_timer_fail,
  input wire reset_pin_oe_n,
  input wire core_reset,
  input wire nmi_mask_bit,
  input wire irq_pin_n,
  input wire irq_edge_select,
  input wire irq_mask_bit,
  input wire irq_request,
  // modes and bus
  input wire [1:0] op_mode,
  input wire bus_cycle_active,
  input wire bus_cycle_write,
  input wire read_write_pin,
  input wire [7:0] port_b_oe_n,
  input wire ports_bus_function
);
  // ----
  // assertions
  // ----
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // a pause or a switch-off may cut a period short, so those cycles are skipped
  chk_bus_period: assert property (disable iff (reset || stop_mode || bus_clock_off)
    $rose(bus_clock_out) |=> bus_clock_out ##1 !bus_clock_out [*2] ##1 bus_clock_out) else $error("bus period");
  chk_stop_hold: assert property (stop_mode [*3] |=> $stable(bus_clock_out) && $stable(clock_out_pin))
    else $error("clock ran in stop");
  chk_div1_rate: assert property ((clock_out_enable_bit && !clock_out_divide_bit1 && !clock_out_divide_bit2
    && !stop_mode) [*3] |=> clock_out_pin != $past(clock_out_pin)) else $error("clock out rate");
  chk_nmi_masked: assert property (disable iff (1'b0) reset |=> nmi_mask_bit) else $error("nmi mask");
  chk_irq_level: assert property ((!irq_pin_n && !irq_edge_select && !irq_mask_bit) [*4] |=> irq_request)
    else $error("held irq not taken");
  chk_mode_hold: assert property (!core_reset && !$past(core_reset) |-> $stable(op_mode))
    else $error("mode changed");
  chk_rw_dir: assert property (op_mode[1] && $stable(op_mode) && bus_cycle_active
    |=> read_write_pin == !$past(bus_cycle_write)) else $error("rw direction");
  chk_rw_single: assert property (!op_mode[1] && $stable(op_mode) |=> !read_write_pin)
    else $error("rw not low");
  chk_ports_bus: assert property (op_mode[1] && $stable(op_mode)
    |=> &port_b_oe_n && ports_bus_function == !$past(core_reset)) else $error("bus port driven");
  chk_access_half: assert property (!stop_mode && !bus_clock_off |=> access_phase == bus_clock_out)
    else $error("access phase");
  chk_ports_rst: assert property (disable iff (1'b0) reset |=> &port_b_oe_n && reset_pin_oe_n)
    else $error("pin driven in reset");
  chk_fail_drive: assert property ((clock_monitor_fail || watchdog_timer_fail) && !core_reset
    |=> (!reset_pin_oe_n && core_reset) [*8]) else $error("failure not driven");
endmodule
bind mpc_pin_ctrl mpc_pin_ctrl_checker u_chk (.*);
`default_nettype wire

//--- mpc_far_side.sv
// Purpose: far side: reset circuit on the reset pin, one irq source
// Assumes: pull-ups on both lines
// Notes: rise_delay mimics a slow rc rise after the pin is let go
`timescale 1ns/100ps
`default_nettype none
module mpc_far_side (
  // clock
  input wire logic clk_sys,
  // reset circuit
  input wire logic reset_pin_oe_n,
  input wire logic ext_press,
  input wire logic [7:0] rise_delay,
  output logic reset_pin_level,
  // interrupt source
  input wire logic irq_event,
  input wire logic irq_ack,
  output logic irq_line_n
);
  logic [7:0] low_cnt = 8'hff;
  initial irq_line_n = 1'b1;
  always @(posedge clk_sys) begin
    if (!reset_pin_oe_n || ext_press)
      low_cnt <= 8'h00;
    else if (low_cnt != 8'hff)
      low_cnt <= low_cnt + 8'h01;
  end
  // pull-up wins only once the rc delay has run out
  assign reset_pin_level = reset_pin_oe_n && !ext_press && low_cnt >= rise_delay;
  always @(posedge clk_sys) begin
    if (irq_event)
      irq_line_n <= 1'b0;
    else if (irq_ack)
      irq_line_n <= 1'b1;
  end
endmodule
`default_nettype wire

//--- test_mcu_pin_control_logic.sv
// Purpose: self-checking bench for the pin control block
// Assumes: inputs change on the falling edge
// Notes: the driver queues expected values, a monitor compares them
`timescale 1ns/100ps
`default_nettype none
module test_mcu_pin_control_logic;
  logic clk_sys, reset, clock_monitor_fail, watchdog_timer_fail, stop_mode, bus_clock_off, irq_edge_select;
  logic clock_out_enable_bit, clock_out_divide_bit1, clock_out_divide_bit2, irq_mask_bit, irq_ack, ext_press;
  logic nonmaskable_interrupt_pin, nmi_mask_clear, mode_select_a, mode_select_b, strobe_drive_control_bit;
  logic opcode_fetch, bus_cycle_active, bus_cycle_write, input_only_pin_g7, input_only_pin_g6, irq_event;
  logic [7:0] port_b_ddr, port_c_ddr, port_f_ddr, port_e_pin, rdly;
  wire reset_pin_n_in, irq_pin_n, reset_pin_out, reset_pin_oe_n, reset_internal_flag, core_reset, access_phase;
  wire bus_clock_out, clock_out_pin, irq_request, nmi_mask_bit, nmi_request, instruction_start_strobe_out;
  wire instruction_start_strobe_oe_n, read_write_pin, ports_bus_function;
  wire [1:0] op_mode;
  wire [7:0] port_b_oe_n, port_c_oe_n, port_f_oe_n;
  wire [9:0] input_only_level;
  logic [13:0] notes[$];
  logic [13:0] nt;
  logic [9:0] rnd;
  logic bc_q, co_q;
  int errors, n_tests, rises, togs, lows;
  event note_ev;
  mpc_pin_ctrl DUT (.*);
  mpc_far_side u_far (
    .clk_sys(clk_sys),
    .reset_pin_oe_n(reset_pin_oe_n),
    .ext_press(ext_press),
    .rise_delay(rdly),
    .reset_pin_level(reset_pin_n_in),
    .irq_event(irq_event),
    .irq_ack(irq_ack),
    .irq_line_n(irq_pin_n)
  );
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    rises += (bus_clock_out && !bc_q);
    togs += (clock_out_pin != co_q);
    lows += (!instruction_start_strobe_oe_n && !instruction_start_strobe_out);
    bc_q = bus_clock_out;
    co_q = clock_out_pin;
  end
  // ----
  // tasks
  // ----
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic note(input logic [3:0] k, input logic [9:0] v);
    notes.push_back({k, v});
    ->note_ev;
  endtask
  task automatic cmp_bit(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic cmp_vec(input string nm, input logic [9:0] e, input logic [9:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_core;
    int k;
    k = 0;
    while (core_reset !== 1'b0 && k < 300) begin
      cyc(1);
      k++;
    end
    errors += (k == 300);
  endtask
  task automatic run_reset(input logic [1:0] m);
    reset = 1'b1;
    {mode_select_b, mode_select_a} = m;
    cyc(5);
    reset = 1'b0;
    wait_core;
  endtask
  task automatic irq_step(input logic ev, input logic ack, input logic exp);
    irq_event = ev;
    irq_ack = ack;
    cyc(1);
    irq_event = 1'b0;
    irq_ack = 1'b0;
    cyc(5);
    note(6, exp);
  endtask
  task automatic window;
    rises = 0;
    togs = 0;
    lows = 0;
    cyc(32);
  endtask
  task automatic print_verdict;
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial forever begin
    @(note_ev);
    while (notes.size() > 0) begin
      nt = notes.pop_front();
      case (nt[13:10])
        4'h0: cmp_bit("reset_internal_flag", nt[0], reset_internal_flag);
        4'h1: cmp_vec("op_mode", nt[9:0], {8'h00, op_mode});
        4'h2: cmp_vec("input_only_level", nt[9:0], input_only_level);
        4'h3: cmp_bit("read_write_pin", nt[0], read_write_pin);
        4'h4: cmp_vec("port_b_oe_n", nt[9:0], {2'h0, port_b_oe_n});
        4'h5: cmp_vec("bus clock rises", nt[9:0], 10'(rises));
        4'h6: cmp_bit("irq_request", nt[0], irq_request);
        4'h7: cmp_bit("nmi_request", nt[0], nmi_request);
        4'h9: cmp_vec("strobe low cycles", nt[9:0], 10'(lows));
        4'ha: cmp_vec("port_c_oe_n", nt[9:0], {2'h0, port_c_oe_n});
        4'hb: cmp_vec("port_f_oe_n", nt[9:0], {2'h0, port_f_oe_n});
        default: cmp_vec("clock out edges", nt[9:0], 10'(togs));
      endcase
    end
  end
  // about forty-five times the expected run length
  initial begin
    #200000;
    errors++;
    print_verdict;
  end
  // ----
  // tests
  // ----
  initial begin
    {clock_monitor_fail, watchdog_timer_fail, stop_mode, bus_clock_off, irq_edge_select, irq_mask_bit} = '0;
    {clock_out_enable_bit, clock_out_divide_bit1, clock_out_divide_bit2, irq_ack, ext_press, irq_event} = '0;
    {nmi_mask_clear, strobe_drive_control_bit, opcode_fetch, bus_cycle_active, bus_cycle_write} = '0;
    {input_only_pin_g7, input_only_pin_g6, port_e_pin, port_b_ddr, port_c_ddr, port_f_ddr, rdly} = '0;
    nonmaskable_interrupt_pin = 1'b1;
    errors = 0;
    n_tests = 0;
    void'($urandom(32'h4dfb));
    for (int m = 0; m < 4; m++) begin
      port_b_ddr = 8'($urandom);
      port_c_ddr = 8'($urandom);
      port_f_ddr = 8'($urandom);
      run_reset(m[1:0]);
      bus_cycle_active = 1'b1;
      bus_cycle_write = 1'b0;
      {mode_select_b, mode_select_a} = ~m[1:0];
      cyc(3);
      note(1, m);
      note(3, m[1]);
      note(4, m[1] ? 10'h0ff : {2'h0, ~port_b_ddr});
      note(10, m[1] ? 10'h0ff : {2'h0, ~port_c_ddr});
      note(11, m[1] ? 10'h0ff : {2'h0, ~port_f_ddr});
      bus_cycle_write = 1'b1;
      cyc(3);
      note(3, 0);
      $display("mode %0d test done", m);
    end
    for (int i = 0; i < 3; i++) begin
      rdly = (i == 0) ? 8'h00 : 8'h28;
      {watchdog_timer_fail, clock_monitor_fail, ext_press} = 3'h4 >> i;
      cyc(i == 2 ? 20 : 1);
      {watchdog_timer_fail, clock_monitor_fail, ext_press} = 3'h0;
      cyc(2);
      wait_core;
      cyc(1);
      note(0, i == 0);
    end
    $display("reset source test done");
    run_reset(2'h3);
    irq_step(1, 0, 1);
    irq_mask_bit = 1'b1;
    irq_step(0, 0, 0);
    irq_mask_bit = 1'b0;
    irq_step(0, 0, 1);
    irq_step(0, 1, 0);
    irq_edge_select = 1'b1;
    irq_step(1, 0, 1);
    irq_step(0, 1, 0);
    nonmaskable_interrupt_pin = 1'b0;
    cyc(5);
    note(7, 0);
    nmi_mask_clear = 1'b1;
    cyc(1);
    nmi_mask_clear = 1'b0;
    cyc(5);
    note(7, 1);
    $display("interrupt test done");
    for (int j = 0; j < 4; j++) begin
      rnd = 10'($urandom);
      {input_only_pin_g7, input_only_pin_g6, port_e_pin} = rnd;
      cyc(4);
      note(2, rnd);
    end
    bus_clock_off = 1'b1;
    clock_out_enable_bit = 1'b1;
    for (int d = 0; d < 4; d++) begin
      {clock_out_divide_bit2, clock_out_divide_bit1} = d[1:0];
      {strobe_drive_control_bit, opcode_fetch} = ~d[1:0];
      cyc(4);
      window;
      note(8, 32 >> d);
      note(9, d == 0 ? 24 : 0);
      note(5, 8);
    end
    stop_mode = 1'b1;
    cyc(4);
    window;
    note(5, 0);
    note(8, 0);
    stop_mode = 1'b0;
    clock_out_enable_bit = 1'b0;
    cyc(4);
    window;
    note(8, 0);
    run_reset(2'h1);
    window;
    note(5, 0);
    $display("clock test done");
    cyc(2);
    print_verdict;
  end
endmodule
`default_nettype wire
